// ---- core/dcpi_pkg.sv ----
// Package for the DDR3 command pin interface block
package dcpi_pkg;

  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W  = 10;
  localparam int NUM_BANKS = 8;

  // Address bit positions
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int TDQS_BIT = 11;
  localparam int ODT_EN_LO = 2;

  // Mode register selects on the bank lines
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR2_SEL = 3'h2;
  localparam logic [2:0] MR3_SEL = 3'h3;

  // Reset values
  localparam logic [13:0] MR_RST = 14'h0000;
  localparam logic [7:0]  BANKS_RST = 8'h00;

  // Burst lengths in beats
  localparam logic [3:0] BL8_BEATS = 4'h8;
  localparam logic [3:0] BC4_BEATS = 4'h4;
  // MR0 burst field: 2'b01 lets A12 choose on the fly
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_ZQ  = 3'h6;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef enum logic [4:0] {
    PWR_ACTIVE = 5'b00001,
    PWR_PPD    = 5'b00010,
    PWR_APD    = 5'b00100,
    PWR_SREF   = 5'b01000,
    PWR_IDLE   = 5'b10000
  } dcpi_pwr_t;

  typedef struct packed {
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic [2:0]  bank;
    logic [13:0] addr;
  } dcpi_cmd_t;

  typedef struct packed {
    logic        actValid;
    logic        rdValid;
    logic        wrValid;
    logic        preValid;
    logic        preAll;
    logic        autoPre;
    logic        mrsValid;
    logic        refValid;
    logic [2:0]  bank;
    logic [13:0] row;
    logic [9:0]  col;
    logic [3:0]  burstLen;
  } dcpi_dec_t;

endpackage

// ---- core/dcpi_command_pins.sv ----
// DDR3 device side command, address and control pin logic
`timescale 1ns/1ps
module dcpi_command_pins #(
  parameter int NBANK = dcpi_pkg::NUM_BANKS
) (
  // Clock, enable, reset
  input  wire logic                 core_clk,
  input  wire logic                 clkEn,
  input  wire logic                 reset,
  // Device pins, already in clock domain except cke and resetN
  input  wire logic                 ckeRaw,
  input  wire logic                 resetNRaw,
  input  wire dcpi_pkg::dcpi_cmd_t  cmdIn,
  input  wire logic                 odtIn,
  input  wire logic                 dmIn,
  input  wire logic                 beatValid,
  // Decoded command
  output dcpi_pkg::dcpi_dec_t       decOut,
  // Power and status
  output dcpi_pkg::dcpi_pwr_t       pwrState,
  output logic [NBANK-1:0]          bankOpen,
  output logic                      bufEnCmd,
  output logic                      bufEnOdt,
  output logic                      termDq,
  output logic                      termTdqsN,
  output logic                      beatKeep,
  output logic                      contentsLost
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] ckeSync_r;
  logic [2:0] rstSync_r;
  logic       cke_r;
  logic       devRstN_r;
  logic [2:0] ckeSync_nxt;
  logic [2:0] rstSync_nxt;

  assign ckeSync_nxt = {ckeSync_r[1:0], ckeRaw};
  assign rstSync_nxt = {rstSync_r[1:0], resetNRaw};

  // Synchronisers run even with clkEn low so CKE exit is seen without the memory clock
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ckeSync_r <= 3'h0;
      rstSync_r <= 3'h0;
    end else begin
      ckeSync_r <= ckeSync_nxt;
      rstSync_r <= rstSync_nxt;
    end
  end

  wire ckeAgree = ckeSync_r[1] == ckeSync_r[2];
  wire rstAgree = rstSync_r[1] == rstSync_r[2];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cke_r     <= 1'b0;
      devRstN_r <= 1'b0;
    end else begin
      if (ckeAgree) begin
        cke_r <= ckeSync_r[2];
      end
      if (rstAgree) begin
        devRstN_r <= rstSync_r[2];
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  logic [13:0] mr0_r;
  logic [13:0] mr1_r;
  logic [13:0] mr2_r;
  logic [NBANK-1:0] bankOpen_r;
  dcpi_pkg::dcpi_pwr_t pwr_r;
  dcpi_pkg::dcpi_pwr_t pwr_nxt;

  function automatic logic isCmd(input dcpi_pkg::dcpi_cmd_t c, input logic [2:0] code);
    isCmd = !c.csN && ({c.rasN, c.casN, c.weN} == code);
  endfunction

  // Sampling happens only on the rising edge with CKE high and device awake
  wire running   = clkEn && devRstN_r && cke_r && (pwr_r == dcpi_pkg::PWR_ACTIVE);
  wire cmdAct    = running && isCmd(cmdIn, dcpi_pkg::CMD_ACT);
  wire cmdRd     = running && isCmd(cmdIn, dcpi_pkg::CMD_RD);
  wire cmdWr     = running && isCmd(cmdIn, dcpi_pkg::CMD_WR);
  wire cmdPre    = running && isCmd(cmdIn, dcpi_pkg::CMD_PRE);
  wire cmdMrs    = running && isCmd(cmdIn, dcpi_pkg::CMD_MRS);
  wire cmdRef    = running && isCmd(cmdIn, dcpi_pkg::CMD_REF);
  wire apBit     = cmdIn.addr[dcpi_pkg::AP_BIT];
  wire bcBit     = cmdIn.addr[dcpi_pkg::BC_BIT];
  wire [1:0] blField = mr0_r[1:0];
  // Chop when MR0 allows on-the-fly selection and A12 is low, or when MR0 fixes four beats
  wire chopOtf   = (blField == dcpi_pkg::BL_OTF) && !bcBit;
  wire chopped   = chopOtf || (blField == dcpi_pkg::BL_FIXED4);
  wire [3:0] burstSel = chopped ? dcpi_pkg::BC4_BEATS : dcpi_pkg::BL8_BEATS;
  wire [NBANK-1:0] bankHot = NBANK'(1) << cmdIn.bank;
  wire anyOpen   = |bankOpen_r;

  dcpi_pkg::dcpi_dec_t dec_nxt;
  always_comb begin
    dec_nxt          = '0;
    dec_nxt.actValid = cmdAct;
    dec_nxt.rdValid  = cmdRd;
    dec_nxt.wrValid  = cmdWr;
    dec_nxt.preValid = cmdPre;
    dec_nxt.preAll   = cmdPre && apBit;
    dec_nxt.autoPre  = (cmdRd || cmdWr) && apBit;
    dec_nxt.mrsValid = cmdMrs;
    dec_nxt.refValid = cmdRef;
    dec_nxt.bank     = cmdIn.bank;
    dec_nxt.row      = cmdIn.addr;
    dec_nxt.col      = cmdIn.addr[dcpi_pkg::COL_W-1:0];
    dec_nxt.burstLen = (cmdRd || cmdWr) ? burstSel : 4'h0;
  end

  // ****************************************
  // Mode registers and banks
  // ****************************************
  logic [NBANK-1:0] bank_nxt;
  always_comb begin
    bank_nxt = bankOpen_r;
    if (cmdAct) begin
      bank_nxt = bankOpen_r | bankHot;
    end else if (cmdPre) begin
      bank_nxt = apBit ? '0 : (bankOpen_r & ~bankHot);
    end else if ((cmdRd || cmdWr) && apBit) begin
      bank_nxt = bankOpen_r & ~bankHot;
    end
  end

  // Device reset wipes mode registers and open banks, even with clkEn low
  always_ff @(posedge core_clk) begin
    if (reset || !devRstN_r) begin
      mr0_r      <= dcpi_pkg::MR_RST;
      mr1_r      <= dcpi_pkg::MR_RST;
      mr2_r      <= dcpi_pkg::MR_RST;
      bankOpen_r <= NBANK'(dcpi_pkg::BANKS_RST);
    end else if (clkEn) begin
      bankOpen_r <= bank_nxt;
      if (cmdMrs && cmdIn.bank == dcpi_pkg::MR0_SEL) begin
        mr0_r <= cmdIn.addr;
      end
      if (cmdMrs && cmdIn.bank == dcpi_pkg::MR1_SEL) begin
        mr1_r <= cmdIn.addr;
      end
      if (cmdMrs && cmdIn.bank == dcpi_pkg::MR2_SEL) begin
        mr2_r <= cmdIn.addr;
      end
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  // A refresh command with CKE falling enters self-refresh when no bank is open
  wire srefEntry = running && isCmd(cmdIn, dcpi_pkg::CMD_REF) && !ckeSync_r[2];
  always_comb begin
    case (pwr_r)
      dcpi_pkg::PWR_ACTIVE: begin
        if (srefEntry && !anyOpen) begin
          pwr_nxt = dcpi_pkg::PWR_SREF;
        end else if (!cke_r) begin
          pwr_nxt = anyOpen ? dcpi_pkg::PWR_APD : dcpi_pkg::PWR_PPD;
        end else begin
          pwr_nxt = dcpi_pkg::PWR_ACTIVE;
        end
      end
      dcpi_pkg::PWR_PPD, dcpi_pkg::PWR_APD: begin
        pwr_nxt = cke_r ? dcpi_pkg::PWR_ACTIVE : pwr_r;
      end
      dcpi_pkg::PWR_SREF: begin
        pwr_nxt = cke_r ? dcpi_pkg::PWR_ACTIVE : dcpi_pkg::PWR_SREF;
      end
      dcpi_pkg::PWR_IDLE: begin
        pwr_nxt = cke_r ? dcpi_pkg::PWR_ACTIVE : dcpi_pkg::PWR_PPD;
      end
      default: begin
        pwr_nxt = dcpi_pkg::PWR_IDLE;
      end
    endcase
  end

  // Self-refresh exit is taken even while clkEn is low
  wire pwrStep = clkEn || (pwr_r == dcpi_pkg::PWR_SREF);
  always_ff @(posedge core_clk) begin
    if (reset || !devRstN_r) begin
      pwr_r <= dcpi_pkg::PWR_IDLE;
    end else if (pwrStep) begin
      pwr_r <= pwr_nxt;
    end
  end

  // ****************************************
  // Termination and data mask
  // ****************************************
  wire inSref    = pwr_r == dcpi_pkg::PWR_SREF;
  wire inPd      = (pwr_r == dcpi_pkg::PWR_PPD) || (pwr_r == dcpi_pkg::PWR_APD);
  wire rttNom    = |{mr1_r[9], mr1_r[6], mr1_r[dcpi_pkg::ODT_EN_LO]};
  wire rttWr     = |mr2_r[10:9];
  wire odtAllow  = (rttNom || rttWr) && !inSref && devRstN_r;
  wire tdqsOn    = mr1_r[dcpi_pkg::TDQS_BIT];
  wire termNxt   = odtIn && odtAllow;
  // Mask only in data mask mode; beat dropped when DM high
  wire keepNxt   = beatValid && !(dmIn && !tdqsOn);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      decOut       <= '0;
      pwrState     <= dcpi_pkg::PWR_IDLE;
      bankOpen     <= '0;
      bufEnCmd     <= 1'b0;
      bufEnOdt     <= 1'b0;
      termDq       <= 1'b0;
      termTdqsN    <= 1'b0;
      beatKeep     <= 1'b0;
      contentsLost <= 1'b1;
    end else if (clkEn) begin
      decOut       <= dec_nxt;
      pwrState     <= pwr_r;
      bankOpen     <= bankOpen_r;
      bufEnCmd     <= cke_r && !inPd && !inSref;
      bufEnOdt     <= !inSref;
      termDq       <= termNxt;
      termTdqsN    <= termNxt && tdqsOn;
      beatKeep     <= keepNxt;
      contentsLost <= contentsLost ? !(cmdAct || cmdWr) : !devRstN_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_cs_masks: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdIn.csN) |=> (decOut.actValid == 1'b0 && decOut.rdValid == 1'b0 && decOut.wrValid == 1'b0))
    else $error("Command taken with chip select high");
  a_sref_odt: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && inSref) |=> !termDq)
    else $error("Termination on in self-refresh");
  a_pre_all: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdPre && apBit) |=> (bankOpen_r == '0))
    else $error("Precharge all left a bank open");
  a_act_opens: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdAct && devRstN_r) |=> bankOpen_r[$past(cmdIn.bank)])
    else $error("Activate did not open bank");
  a_autopre_bit: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && (cmdRd || cmdWr)) |=> (decOut.autoPre == $past(apBit)))
    else $error("Auto-precharge flag wrong");
  a_chop_len: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdRd && blField == dcpi_pkg::BL_OTF && !bcBit) |=> (decOut.burstLen == 4'h4))
    else $error("Chopped burst not four beats");
  a_dm_drop: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && beatValid && dmIn && !tdqsOn) |=> !beatKeep)
    else $error("Masked beat kept");
  a_pd_open: assert property (@(posedge core_clk) disable iff (reset || !devRstN_r)
    (clkEn && pwr_r == dcpi_pkg::PWR_ACTIVE && !cke_r && anyOpen && !srefEntry) |=> (pwr_r == dcpi_pkg::PWR_APD))
    else $error("Open row did not give active power-down");
  a_rst_wipe: assert property (@(posedge core_clk) disable iff (reset)
    !devRstN_r |=> (bankOpen_r == '0 && mr0_r == '0))
    else $error("State survived device reset");
  a_cke_stop: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && !cke_r) |=> !decOut.rdValid)
    else $error("Command taken with CKE low");
  a_pre_one: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdPre && !apBit) |=> (bankOpen_r == ($past(bankOpen_r) & ~$past(bankHot))))
    else $error("Single precharge closed the wrong banks");
  a_ap_close: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && (cmdRd || cmdWr) && apBit) |=> !bankOpen_r[$past(cmdIn.bank)])
    else $error("Auto-precharge left the bank open");
  a_full_burst: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && (cmdRd || cmdWr) && blField == dcpi_pkg::BL_OTF && bcBit) |=> (decOut.burstLen == 4'h8))
    else $error("Unchopped burst not eight beats");
  a_fixed_len: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && (cmdRd || cmdWr) && blField != dcpi_pkg::BL_OTF && blField != dcpi_pkg::BL_FIXED4)
    |=> (decOut.burstLen == 4'h8))
    else $error("Burst chopped without mode permission");
  a_mrs_load: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdMrs && cmdIn.bank == dcpi_pkg::MR0_SEL) |=> (mr0_r == $past(cmdIn.addr)))
    else $error("Mode register not loaded from address");
  a_row_addr: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && cmdAct) |=> (decOut.actValid && decOut.row == $past(cmdIn.addr)))
    else $error("Row address not passed with activate");
  a_col_addr: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && (cmdRd || cmdWr)) |=> (decOut.col == $past(cmdIn.addr[dcpi_pkg::COL_W-1:0])))
    else $error("Column address not passed");
  a_pd_idle: assert property (@(posedge core_clk) disable iff (reset || !devRstN_r)
    (clkEn && pwr_r == dcpi_pkg::PWR_ACTIVE && !cke_r && !anyOpen) |=> (pwr_r == dcpi_pkg::PWR_PPD))
    else $error("Idle banks did not give precharge power-down");
  a_sref_entry: assert property (@(posedge core_clk) disable iff (reset || !devRstN_r)
    (clkEn && srefEntry && !anyOpen) |=> (pwr_r == dcpi_pkg::PWR_SREF))
    else $error("Refresh with CKE falling did not enter self-refresh");
  a_sref_exit: assert property (@(posedge core_clk) disable iff (reset || !devRstN_r)
    (pwr_r == dcpi_pkg::PWR_SREF && cke_r) |=> (pwr_r == dcpi_pkg::PWR_ACTIVE))
    else $error("Self-refresh exit waited for clock enable");
  a_pd_bufs: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && inPd) |=> (!bufEnCmd && bufEnOdt))
    else $error("Wrong buffers enabled in power-down");
  a_sref_bufs: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && inSref) |=> (!bufEnCmd && !bufEnOdt))
    else $error("Buffers enabled in self-refresh");
  a_odt_term: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && odtIn && odtAllow) |=> (termDq && termTdqsN == $past(tdqsOn)))
    else $error("Termination not applied with ODT high");
  a_rtt_off: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && !rttNom && !rttWr) |=> !termDq)
    else $error("Termination on with mode registers off");
  a_beat_keep: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && beatValid && !dmIn) |=> beatKeep)
    else $error("Unmasked beat dropped");
  a_rst_empty: assert property (@(posedge core_clk) disable iff (reset)
    (clkEn && !devRstN_r) |=> (!decOut.actValid && !decOut.wrValid && contentsLost))
    else $error("Access or contents seen during device reset");
  a_cke_filter: assert property (@(posedge core_clk) disable iff (reset)
    (ckeSync_r[1] != ckeSync_r[2]) |=> $stable(cke_r))
    else $error("CKE accepted before synchroniser agreed");

endmodule

// ---- bench/dcpi_ctrl_model.sv ----
// Controller model driving command, control and data mask pins
`timescale 1ns/1ps
module dcpi_ctrl_model (
  // Clock
  input  wire logic           core_clk,
  // Pins toward the device
  output dcpi_pkg::dcpi_cmd_t cmd,
  output logic                cke,
  output logic                rstN,
  output logic                odt,
  output logic                dm,
  output logic                beat
);
  initial begin
    cmd  = '1;
    cke  = 1'b0;
    rstN = 1'b0;
    odt  = 1'b0;
    dm   = 1'b0;
    beat = 1'b0;
  end
  // Deselect after each command; lines flip so no stale value lingers
  task automatic send(input logic cs, input logic [2:0] code, input logic [2:0] ba, input logic [13:0] a);
    @(posedge core_clk);
    cmd <= {cs, code, ba, a};
    @(posedge core_clk);
    cmd <= {1'b1, 3'h7, ~ba, ~a};
  endtask
  task automatic pins(input logic c, input logic r, input logic o);
    @(posedge core_clk);
    cke  <= c;
    rstN <= r;
    odt  <= o;
  endtask
  task automatic dataBeat(input logic m);
    @(posedge core_clk);
    beat <= 1'b1;
    dm   <= m;
    @(posedge core_clk);
    beat <= 1'b0;
    dm   <= ~m;
  endtask
endmodule

// ---- bench/dcpi_command_pins_tb.sv ----
// Self-checking testbench for the command pin block
`timescale 1ns/1ps
module dcpi_command_pins_tb;
  logic                core_clk = 1'b0;
  logic                reset    = 1'b1;
  logic                clkEn    = 1'b1;
  dcpi_pkg::dcpi_cmd_t cmd;
  logic                cke, rstN, odt, dm, beat;
  dcpi_pkg::dcpi_dec_t dec;
  dcpi_pkg::dcpi_pwr_t pwr;
  logic [7:0]          bankOpen;
  logic                bufEnCmd, bufEnOdt, termDq, termTdqsN, beatKeep, contentsLost;
  wire  [5:0]          vld = {dec.actValid, dec.rdValid, dec.wrValid, dec.preValid, dec.mrsValid, dec.refValid};
  int                  err_total = 0;
  int                  n_tests   = 0;

  always #12.5 core_clk = ~core_clk;

  dcpi_ctrl_model dcpi_ctrl_model_inst (.core_clk(core_clk), .cmd(cmd), .cke(cke), .rstN(rstN), .odt(odt),
    .dm(dm), .beat(beat));
  dcpi_command_pins dcpi_command_pins_inst (.core_clk(core_clk), .clkEn(clkEn), .reset(reset), .ckeRaw(cke),
    .resetNRaw(rstN), .cmdIn(cmd), .odtIn(odt), .dmIn(dm), .beatValid(beat), .decOut(dec), .pwrState(pwr),
    .bankOpen(bankOpen), .bufEnCmd(bufEnCmd), .bufEnOdt(bufEnOdt), .termDq(termDq), .termTdqsN(termTdqsN),
    .beatKeep(beatKeep), .contentsLost(contentsLost));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Command driven at the next edge and taken at the one after; result looked at in the cycle it stands
  task automatic issue(input logic cs, input logic [2:0] code, input logic [2:0] ba, input logic [13:0] a);
    dcpi_ctrl_model_inst.send(cs, code, ba, a);
    #1;
  endtask
  // Bounded wait; synchroniser delay is not fixed to one edge
  task automatic waitPwr(input dcpi_pkg::dcpi_pwr_t s);
    for (int i = 0; i < 16 && pwr !== s; i++) begin
      cyc(1);
    end
    chk(pwr, s);
  endtask
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bringUp();
    chk(pwr, dcpi_pkg::PWR_IDLE);
    chk(contentsLost, 1'b1);
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b0);
    waitPwr(dcpi_pkg::PWR_ACTIVE);
  endtask
  task automatic t_mrs();
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR0_SEL, 14'h0001);
    chk(vld, 6'h02);
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR1_SEL, 14'h0804);
    chk(dec.bank, dcpi_pkg::MR1_SEL);
  endtask
  task automatic t_rowCol();
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h2, 14'h3a5c);
    chk({vld, dec.bank, dec.row}, {6'h20, 3'h2, 14'h3a5c});
    cyc(1);
    chk(bankOpen, 8'h04);
    chk(contentsLost, 1'b0);
    issue(1'b0, dcpi_pkg::CMD_RD, 3'h2, 14'h02ff);
    chk({vld, dec.col, dec.autoPre}, {6'h10, 10'h2ff, 1'b0});
    chk(dec.burstLen, dcpi_pkg::BC4_BEATS);
    issue(1'b0, dcpi_pkg::CMD_WR, 3'h2, 14'h1401);
    chk({vld, dec.autoPre}, {6'h08, 1'b1});
    chk(dec.burstLen, dcpi_pkg::BL8_BEATS);
    cyc(1);
    chk(bankOpen, 8'h00);
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR0_SEL, 14'h0000);
    issue(1'b0, dcpi_pkg::CMD_RD, 3'h2, 14'h0000);
    chk(dec.burstLen, dcpi_pkg::BL8_BEATS);
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR0_SEL, 14'h0002);
    issue(1'b0, dcpi_pkg::CMD_WR, 3'h2, 14'h1000);
    chk(dec.burstLen, dcpi_pkg::BC4_BEATS);
  endtask
  task automatic t_pre();
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h1, 14'h0011);
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h5, 14'h0022);
    issue(1'b0, dcpi_pkg::CMD_PRE, 3'h1, 14'h0000);
    chk({dec.preValid, dec.preAll}, 2'b10);
    cyc(1);
    chk(bankOpen, 8'h20);
    issue(1'b0, dcpi_pkg::CMD_PRE, 3'h0, 14'h0400);
    chk(dec.preAll, 1'b1);
    cyc(1);
    chk(bankOpen, 8'h00);
  endtask
  task automatic t_ignore();
    issue(1'b1, dcpi_pkg::CMD_ACT, 3'h3, 14'h0001);
    chk(vld, 6'h00);
    @(posedge core_clk);
    clkEn <= 1'b0;
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h3, 14'h0001);
    chk(vld, 6'h00);
    @(posedge core_clk);
    clkEn <= 1'b1;
    cyc(1);
    chk(bankOpen, 8'h00);
  endtask
  task automatic t_termMask();
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    cyc(3);
    chk({termDq, termTdqsN}, 2'b11);
    dcpi_ctrl_model_inst.dataBeat(1'b1);
    #1;
    chk(beatKeep, 1'b1);
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR1_SEL, 14'h0004);
    cyc(2);
    chk({termDq, termTdqsN}, 2'b10);
    dcpi_ctrl_model_inst.dataBeat(1'b1);
    #1;
    chk(beatKeep, 1'b0);
    dcpi_ctrl_model_inst.dataBeat(1'b0);
    #1;
    chk(beatKeep, 1'b1);
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR1_SEL, 14'h0000);
    cyc(2);
    chk(termDq, 1'b0);
  endtask
  task automatic t_power();
    dcpi_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    waitPwr(dcpi_pkg::PWR_PPD);
    cyc(1);
    chk({bufEnCmd, bufEnOdt}, 2'b01);
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h3, 14'h0005);
    chk(vld, 6'h00);
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    waitPwr(dcpi_pkg::PWR_ACTIVE);
    issue(1'b0, dcpi_pkg::CMD_ACT, 3'h0, 14'h0003);
    dcpi_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    waitPwr(dcpi_pkg::PWR_APD);
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    waitPwr(dcpi_pkg::PWR_ACTIVE);
  endtask
  task automatic t_devReset();
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR1_SEL, 14'h0004);
    dcpi_ctrl_model_inst.pins(1'b1, 1'b0, 1'b1);
    waitPwr(dcpi_pkg::PWR_IDLE);
    cyc(1);
    chk({bankOpen, contentsLost}, {8'h00, 1'b1});
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    waitPwr(dcpi_pkg::PWR_ACTIVE);
    cyc(2);
    chk(termDq, 1'b0);
  endtask
  task automatic t_sref();
    issue(1'b0, dcpi_pkg::CMD_MRS, dcpi_pkg::MR1_SEL, 14'h0004);
    dcpi_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    // Refresh must meet the edge where CKE has just cleared the synchroniser
    cyc(2);
    issue(1'b0, dcpi_pkg::CMD_REF, 3'h0, 14'h0000);
    chk(vld, 6'h01);
    waitPwr(dcpi_pkg::PWR_SREF);
    cyc(1);
    chk({bufEnCmd, bufEnOdt, termDq}, 3'b000);
    @(posedge core_clk);
    clkEn <= 1'b0;
    dcpi_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    cyc(8);
    @(posedge core_clk);
    clkEn <= 1'b1;
    cyc(1);
    chk(pwr, dcpi_pkg::PWR_ACTIVE);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    cyc(1);
    t_bringUp();
    t_mrs();
    t_rowCol();
    t_pre();
    t_ignore();
    t_termMask();
    t_power();
    t_devReset();
    t_sref();
    end_of_test();
  end
  initial begin
    #(25 * 5000);
    err_total++;
    end_of_test();
  end
endmodule
